/* src/fshc_top.sv */
// type I seek sequencer with head-load control and an apb register file
//
// Notes on behaviour
// - step pulse is 2 us double density, 4 us single density
// - keep last step direction unless the command picks a new one
// - direction high inward, low outward, settled before the pulse
// - rate field picks 3, 6, 10, 15 ms between steps, doubled slow
// - verify adds 15 ms settling after last step, 30 ms slow
// - verify: first matching id with good crc ends cleanly
// - matching id with bad crc sets crc error and keeps looking
// - no good match in 5 revolutions sets seek error, interrupts
// - head load set at start if h, at end if verify, on type ii/iii
// - head load drops on h=0 v=0 command or 15 idle index pulses
// - media used only with head load and engaged; status bit 5 ands them
// - h=1 v=0 never samples engaged; v=1 settles then waits engaged
// - type ii/iii load head, optional 15 ms, then wait engaged
// - restore: at track zero clear track, else step out until there
// - restore gives up after 255 pulses with seek error
// - master reset release launches a restore
// - seek steps track register toward data register, then verify option
// - step pulses in old direction, optional update, rate delay, verify
// - step-in pulses inward, increments track when update flag set
// - step-out pulses outward, decrements track when update flag set
// - type i leaves side select and does no side compare
// - test low gives a write data pulse train, write gate held off
// - test low at master reset release picks external recovery
// - type i word: rate bits 1:0, verify 2, head load 3, update 4
//
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/100ps
module fshc_top #(
  parameter int MS_CYCLES = fshc_pkg::MS_CYC
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // device pins
  input wire logic master_reset_n,
  input wire logic test_n,
  input wire logic density_select_n,
  input wire logic slow_clock_sel,
  input wire logic track_zero_n,
  input wire logic head_engaged,
  input wire logic index_pulse,
  // id fields from the read channel
  input wire logic id_valid,
  input wire logic [7:0] id_track,
  input wire logic id_crc_ok,
  // drive and status outputs
  output logic step_pulse,
  output logic step_direction,
  output logic head_load,
  output logic side_select_out,
  output logic interrupt_request,
  output logic write_data,
  output logic write_gate,
  output logic ext_recovery_sel
);
  fshc_tmr_if tmr ();
  fshc_pkg::fshc_state_t st_q, st_d;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q;
  logic [7:0] cmd_q, track_q, data_q, pcount_q;
  logic [8:0] pw_q, wd_cnt_q;
  logic [2:0] revs_q;
  logic [3:0] idle_idx_q;
  logic t23_q, busy_q, irq_q, crc_err_q, seek_err_q, dir_q, hl_q, side_q, step_q;
  logic wd_q, wg_q, ext_q, mr_prev_q, idx_prev_q;
  logic acc, wr, rd, cmd_wr, force_int, accept, mr_rise, idx_rise, id_take, id_match;
  logic step_more, new_dir, go_post, give_up;
  logic [7:0] acc_cmd;
  logic [8:0] pw_len;
  logic [3:0] op;
  logic [7:0] status;

  // rate code to milliseconds, doubled on the slow clock
  function automatic logic [5:0] fshc_rate_ms(input logic [1:0] code, input logic slow);
    logic [5:0] ms;
    ms = fshc_pkg::RATE0_MS;
    unique case (code)
      2'b00: ms = fshc_pkg::RATE0_MS;
      2'b01: ms = fshc_pkg::RATE1_MS;
      2'b10: ms = fshc_pkg::RATE2_MS;
      2'b11: ms = fshc_pkg::RATE3_MS;
    endcase
    return slow ? {ms[4:0], 1'b0} : ms;
  endfunction

  // bus strobes and command decode
  assign acc = psel && penable && pready_q;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign cmd_wr = wr && paddr == fshc_pkg::REG_CMD && master_reset_n;
  assign force_int = cmd_wr && pwdata[7:4] == 4'hd;
  assign mr_rise = master_reset_n && !mr_prev_q;
  assign accept = mr_rise || (cmd_wr && !force_int && !busy_q);
  assign acc_cmd = mr_rise ? fshc_pkg::MR_RESTORE_CMD : pwdata[7:0];
  assign op = cmd_q[7:4];
  assign idx_rise = index_pulse && !idx_prev_q;
  assign id_take = id_valid && hl_q && head_engaged;
  // track only; side never compared in type i verify
  assign id_match = id_take && id_track == track_q;
  assign pw_len = density_select_n ? fshc_pkg::STEP_FM_CYC : fshc_pkg::STEP_MFM_CYC;
  assign status = {2'b00, hl_q && head_engaged, seek_err_q, crc_err_q, !track_zero_n,
                   index_pulse, busy_q};

  // per-command stepping decision, evaluated in the check state
  always_comb begin
    step_more = 1'b0;
    new_dir = dir_q;
    go_post = 1'b0;
    give_up = 1'b0;
    if (op == 4'h0) begin
      if (!track_zero_n) begin
        go_post = 1'b1;
      end else if (pcount_q == fshc_pkg::RESTORE_MAX) begin
        give_up = 1'b1;
      end else begin
        step_more = 1'b1;
        new_dir = 1'b0;
      end
    end else if (op == 4'h1) begin
      if (track_q == data_q) begin
        go_post = 1'b1;
      end else begin
        step_more = 1'b1;
        new_dir = data_q > track_q;
      end
    end else if (pcount_q != 8'h0) begin
      go_post = 1'b1;
    end else begin
      step_more = 1'b1;
      if (op[3:1] == 3'b010) begin
        new_dir = 1'b1;
      end else if (op[3:1] == 3'b011) begin
        new_dir = 1'b0;
      end
    end
  end

  // next state and delay requests
  always_comb begin
    st_d = st_q;
    tmr.start = 1'b0;
    tmr.ms = fshc_pkg::SETTLE_MS;
    if (!master_reset_n) begin
      st_d = fshc_pkg::S_IDLE;
    end else if (force_int) begin
      st_d = pwdata[3:0] != 4'h0 ? fshc_pkg::S_DONE : fshc_pkg::S_IDLE;
    end else if (accept) begin
      if (acc_cmd[7] == 1'b0) begin
        st_d = fshc_pkg::S_CHECK;
      end else if (acc_cmd[fshc_pkg::CMD_DELAY]) begin
        st_d = fshc_pkg::S_SETTLE;
        tmr.start = 1'b1;
      end else begin
        st_d = fshc_pkg::S_WAIT_HE;
      end
    end else begin
      unique case (st_q)
        fshc_pkg::S_IDLE: st_d = fshc_pkg::S_IDLE;
        fshc_pkg::S_CHECK: begin
          if (give_up) begin
            st_d = fshc_pkg::S_DONE;
          end else if (step_more) begin
            st_d = fshc_pkg::S_DIR;
          end else if (go_post && cmd_q[fshc_pkg::CMD_VERIFY]) begin
            st_d = fshc_pkg::S_SETTLE;
            tmr.start = 1'b1;
          end else begin
            st_d = fshc_pkg::S_DONE;
          end
        end
        fshc_pkg::S_DIR: st_d = fshc_pkg::S_PULSE;
        fshc_pkg::S_PULSE: begin
          if (pw_q == pw_len - 9'h1) begin
            st_d = fshc_pkg::S_RATE;
            tmr.start = 1'b1;
            tmr.ms = fshc_rate_ms(cmd_q[fshc_pkg::CMD_RATE_LO +: 2], slow_clock_sel);
          end
        end
        fshc_pkg::S_RATE: st_d = tmr.done ? fshc_pkg::S_CHECK : fshc_pkg::S_RATE;
        fshc_pkg::S_SETTLE: st_d = tmr.done ? fshc_pkg::S_WAIT_HE : fshc_pkg::S_SETTLE;
        fshc_pkg::S_WAIT_HE: begin
          if (hl_q && head_engaged) begin
            st_d = t23_q ? fshc_pkg::S_DONE : fshc_pkg::S_VERIFY;
          end
        end
        fshc_pkg::S_VERIFY: begin
          if ((id_match && id_crc_ok) || revs_q == fshc_pkg::VERIFY_REVS) begin
            st_d = fshc_pkg::S_DONE;
          end
        end
        fshc_pkg::S_DONE: st_d = fshc_pkg::S_IDLE;
        default: st_d = fshc_pkg::S_IDLE;
      endcase
    end
    if (slow_clock_sel && st_d == fshc_pkg::S_SETTLE) begin
      tmr.ms = {fshc_pkg::SETTLE_MS[4:0], 1'b0};
    end
  end

  // sequencer state, command and counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= fshc_pkg::S_IDLE;
      cmd_q <= 8'h0;
      t23_q <= 1'b0;
      pcount_q <= 8'h0;
      pw_q <= 9'h0;
      revs_q <= 3'h0;
      mr_prev_q <= 1'b0;
      idx_prev_q <= 1'b0;
    end else begin
      st_q <= st_d;
      mr_prev_q <= master_reset_n;
      idx_prev_q <= index_pulse;
      pw_q <= st_q == fshc_pkg::S_PULSE ? pw_q + 9'h1 : 9'h0;
      if (accept) begin
        cmd_q <= acc_cmd;
        t23_q <= acc_cmd[7];
        pcount_q <= 8'h0;
      end else if (st_q == fshc_pkg::S_DIR) begin
        pcount_q <= pcount_q + 8'h1;
      end
      if (st_q != fshc_pkg::S_VERIFY) begin
        revs_q <= 3'h0;
      end else if (idx_rise) begin
        revs_q <= revs_q + 3'h1;
      end
    end
  end

  // drive outputs: step, direction, track register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_q <= 1'b0;
      dir_q <= 1'b0;
      track_q <= fshc_pkg::TRACK_RST;
    end else begin
      step_q <= st_d == fshc_pkg::S_PULSE;
      if (st_q == fshc_pkg::S_CHECK && step_more) begin
        dir_q <= new_dir;
      end
      if (st_q == fshc_pkg::S_CHECK && op == 4'h0 && !track_zero_n) begin
        track_q <= 8'h0;
      end else if (st_q == fshc_pkg::S_DIR && (op == 4'h1 || (op != 4'h0 &&
                   cmd_q[fshc_pkg::CMD_UPDATE]))) begin
        track_q <= dir_q ? track_q + 8'h1 : track_q - 8'h1;
      end else if (wr && paddr == fshc_pkg::REG_TRACK && !busy_q) begin
        track_q <= pwdata[7:0];
      end
    end
  end

  // head load and side select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hl_q <= 1'b0;
      side_q <= 1'b0;
      idle_idx_q <= 4'h0;
    end else begin
      if (busy_q || accept) begin
        idle_idx_q <= 4'h0;
      end else if (idx_rise && hl_q) begin
        idle_idx_q <= idle_idx_q + 4'h1;
      end
      if (accept && acc_cmd[7]) begin
        hl_q <= 1'b1;
        side_q <= acc_cmd[fshc_pkg::CMD_SIDE];
      end else if (accept) begin
        if (acc_cmd[fshc_pkg::CMD_HLOAD]) begin
          hl_q <= 1'b1;
        end else if (!acc_cmd[fshc_pkg::CMD_VERIFY]) begin
          hl_q <= 1'b0;
        end
      end else if (st_d == fshc_pkg::S_SETTLE && !t23_q) begin
        hl_q <= 1'b1;
      end else if (idle_idx_q == fshc_pkg::HL_IDLE_INDEX && !busy_q) begin
        hl_q <= 1'b0;
      end
    end
  end

  // busy, errors and interrupt request; a set beats a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'b0;
      irq_q <= 1'b0;
      crc_err_q <= 1'b0;
      seek_err_q <= 1'b0;
    end else begin
      busy_q <= st_d != fshc_pkg::S_IDLE;
      if (st_q == fshc_pkg::S_DONE) begin
        irq_q <= 1'b1;
      end else if (cmd_wr || (rd && paddr == fshc_pkg::REG_STATUS)) begin
        irq_q <= 1'b0;
      end
      if (st_q == fshc_pkg::S_VERIFY && id_match && !id_crc_ok) begin
        crc_err_q <= 1'b1;
      end else if (accept) begin
        crc_err_q <= 1'b0;
      end
      if ((st_q == fshc_pkg::S_CHECK && give_up) || (st_q == fshc_pkg::S_VERIFY &&
          st_d == fshc_pkg::S_DONE && !(id_match && id_crc_ok))) begin
        seek_err_q <= 1'b1;
      end else if (accept) begin
        seek_err_q <= 1'b0;
      end
    end
  end

  // test mode pulse train and recovery select caught at reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_cnt_q <= 9'h0;
      wd_q <= 1'b0;
      wg_q <= 1'b0;
      ext_q <= 1'b0;
    end else begin
      wd_cnt_q <= wd_cnt_q == fshc_pkg::WD_PERIOD_CYC - 9'h1 ? 9'h0 : wd_cnt_q + 9'h1;
      wd_q <= !test_n && wd_cnt_q == 9'h0;
      wg_q <= 1'b0; // no sector writes here, so the gate stays off
      if (mr_rise) begin
        ext_q <= !test_n;
      end
    end
  end

  // apb slave: one wait state, registered read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= psel && penable && !pready_q;
      pslverr_q <= 1'b0;
      if (psel && penable && !pready_q) begin
        prdata_q <= 32'h0;
        unique case (paddr)
          fshc_pkg::REG_STATUS: prdata_q <= {24'h0, status};
          fshc_pkg::REG_CMD: prdata_q <= {24'h0, cmd_q};
          fshc_pkg::REG_TRACK: prdata_q <= {24'h0, track_q};
          fshc_pkg::REG_DATA: prdata_q <= {24'h0, data_q};
          fshc_pkg::REG_INFO: prdata_q <= {29'h0, ext_q, dir_q, hl_q};
          default: pslverr_q <= 1'b1;
        endcase
      end
    end
  end

  // destination track register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_q <= fshc_pkg::DATA_RST;
    end else if (wr && paddr == fshc_pkg::REG_DATA) begin
      data_q <= pwdata[7:0];
    end
  end

  fshc_delay #(.MS_CYCLES(MS_CYCLES)) u_delay (.pclk(pclk), .presetn(presetn), .t(tmr));

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign step_pulse = step_q;
  assign step_direction = dir_q;
  assign head_load = hl_q;
  assign side_select_out = side_q;
  assign interrupt_request = irq_q;
  assign write_data = wd_q;
  assign write_gate = wg_q;
  assign ext_recovery_sel = ext_q;

  // checks
  step_width_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(step_q) |-> $past(pw_q) == pw_len - 9'h1) else $error("step pulse width wrong");
  dir_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(step_q) |-> $stable(dir_q) ##1 $stable(dir_q)) else $error("direction moved at step");
  dir_change_a: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(dir_q) |-> $past(st_q) == fshc_pkg::S_CHECK) else $error("direction changed late");
  restore_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_q == fshc_pkg::S_CHECK && op == 4'h0 && !track_zero_n && !accept |=> track_q == 8'h0)
    else $error("restore did not clear track");
  restore_limit_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_q == fshc_pkg::S_CHECK && give_up && !accept |=> seek_err_q ##1 irq_q)
    else $error("restore limit not flagged");
  verify_ok_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_q == fshc_pkg::S_VERIFY && id_match && id_crc_ok && master_reset_n && !cmd_wr
    |=> st_q == fshc_pkg::S_DONE ##1 irq_q && !busy_q) else $error("verify match not ended");
  crc_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_q == fshc_pkg::S_VERIFY && id_match && !id_crc_ok && !accept |=> crc_err_q)
    else $error("crc error not set");
  busy_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(irq_q) |-> !busy_q && $past(busy_q)) else $error("busy not cleared with irq");
  test_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    !test_n |=> !wg_q) else $error("write gate on in test");
endmodule

/* src/fshc_pkg.sv */
// constants, register map and state encoding of the seek and head-load sequencer
package fshc_pkg;
  // clock and timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int STEP_MFM_US = 2;
  localparam int STEP_FM_US = 4;
  localparam logic [8:0] STEP_MFM_CYC = 9'(STEP_MFM_US * 1000 / CLK_PERIOD_NS);
  localparam logic [8:0] STEP_FM_CYC = 9'(STEP_FM_US * 1000 / CLK_PERIOD_NS);
  localparam int MS_NS = 1000000;
  localparam int MS_CYC = MS_NS / CLK_PERIOD_NS;
  localparam logic [5:0] RATE0_MS = 6'h03;
  localparam logic [5:0] RATE1_MS = 6'h06;
  localparam logic [5:0] RATE2_MS = 6'h0a;
  localparam logic [5:0] RATE3_MS = 6'h0f;
  localparam logic [5:0] SETTLE_MS = 6'h0f;
  localparam logic [8:0] WD_PERIOD_CYC = 9'h0c8;
  // sequencing limits
  localparam logic [7:0] RESTORE_MAX = 8'hff;
  localparam logic [2:0] VERIFY_REVS = 3'h5;
  localparam logic [3:0] HL_IDLE_INDEX = 4'hf;
  localparam logic [7:0] MR_RESTORE_CMD = 8'h03;
  // register byte offsets
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_TRACK = 8'h08;
  localparam logic [7:0] REG_DATA = 8'h0c;
  localparam logic [7:0] REG_INFO = 8'h10;
  localparam logic [7:0] TRACK_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  // command word fields
  localparam int CMD_RATE_LO = 0;
  localparam int CMD_VERIFY = 2;
  localparam int CMD_HLOAD = 3;
  localparam int CMD_UPDATE = 4;
  localparam int CMD_DELAY = 2;
  localparam int CMD_SIDE = 1;
  // status bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_INDEX = 1;
  localparam int ST_TRK0 = 2;
  localparam int ST_CRC = 3;
  localparam int ST_SEEK = 4;
  localparam int ST_HEAD = 5;
  // sequencer states, gray from S_CHECK through S_DIR and S_PULSE to S_RATE
  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_CHECK = 4'h1,
    S_DIR = 4'h3,
    S_PULSE = 4'h2,
    S_RATE = 4'h6,
    S_SETTLE = 4'h7,
    S_WAIT_HE = 4'h5,
    S_VERIFY = 4'h4,
    S_DONE = 4'hc
  } fshc_state_t;
endpackage

/* src/fshc_tmr_if.sv */
// millisecond delay request between sequencer and delay unit
`timescale 1ns/100ps
interface fshc_tmr_if;
  logic start;
  logic [5:0] ms;
  logic done;
  modport seq (output start, output ms, input done);
  modport timer (input start, input ms, output done);
endinterface

/* src/fshc_delay.sv */
// millisecond delay unit with a prescaler
`timescale 1ns/100ps
module fshc_delay #(
  parameter int MS_CYCLES = fshc_pkg::MS_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // request
  fshc_tmr_if.timer t
);
  logic [31:0] pre_q;
  logic [5:0] left_q;
  logic run_q;
  logic done_q;

  // count whole milliseconds, one pulse on done at the end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= 32'h0;
      left_q <= 6'h0;
      run_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (t.start) begin
        pre_q <= 32'h0;
        left_q <= t.ms;
        run_q <= 1'b1;
      end else if (run_q) begin
        if (pre_q == 32'(MS_CYCLES - 1)) begin
          pre_q <= 32'h0;
          left_q <= left_q - 6'h1;
          if (left_q <= 6'h1) begin
            run_q <= 1'b0;
            done_q <= 1'b1;
          end
        end else begin
          pre_q <= pre_q + 32'h1;
        end
      end
    end
  end

  assign t.done = done_q;
endmodule

/* verif/fshc_drive_model.sv */
// behavioural floppy drive: head position, track zero, head engage, index and id fields
`timescale 1ns/100ps
module fshc_drive_model #(
  parameter int ENGAGE_CYC = 40,
  parameter int INDEX_CYC = 400,
  parameter int ID_CYC = 90,
  parameter int QUIET_CYC = 250
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // from the controller
  input wire logic step_pulse,
  input wire logic step_direction,
  input wire logic head_load,
  // bench controls
  input wire logic [7:0] start_cyl,
  input wire logic tz_broken,
  input wire logic [7:0] id_skew,
  input wire logic [1:0] bad_crcs,
  // to the controller
  output logic track_zero_n,
  output logic head_engaged,
  output logic index_pulse,
  output logic id_valid,
  output logic [7:0] id_track,
  output logic id_crc_ok
);
  logic [7:0] cyl_q;
  logic step_q;
  int eng_q;
  int rev_q;
  int id_q;
  int id_n;
  int quiet_q;
  // head moves one cylinder per step rise, stops at the outer stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyl_q <= start_cyl;
      step_q <= 1'b0;
    end else begin
      step_q <= step_pulse;
      if (step_pulse && !step_q) begin
        if (step_direction) begin
          cyl_q <= cyl_q + 8'h01;
        end else if (cyl_q != 8'h00) begin
          cyl_q <= cyl_q - 8'h01;
        end
      end
    end
  end
  assign track_zero_n = tz_broken | (cyl_q != 8'h00);
  assign head_engaged = head_load && (eng_q >= ENGAGE_CYC);
  // engage delay, index and id fields; id lines wander while not qualified
  // no id is read while the head still rings after a step, so bad crcs land in verify
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eng_q <= 0;
      rev_q <= 0;
      id_q <= 0;
      id_n <= 0;
      quiet_q <= 0;
      index_pulse <= 1'b0;
      id_valid <= 1'b0;
      id_track <= 8'h00;
      id_crc_ok <= 1'b0;
    end else begin
      eng_q <= head_load ? eng_q + 1 : 0;
      rev_q <= (rev_q == INDEX_CYC - 1) ? 0 : rev_q + 1;
      index_pulse <= (rev_q == 0);
      id_q <= (id_q == ID_CYC - 1) ? 0 : id_q + 1;
      id_valid <= 1'b0;
      id_track <= ~id_track;
      id_crc_ok <= ~id_crc_ok;
      quiet_q <= step_pulse ? QUIET_CYC : (quiet_q > 0 ? quiet_q - 1 : 0);
      if (!head_engaged || step_pulse) begin
        id_n <= 0;
      end else if (id_q == 0 && quiet_q == 0) begin
        id_valid <= 1'b1;
        id_track <= cyl_q + id_skew;
        id_crc_ok <= (id_n >= int'(bad_crcs));
        id_n <= id_n + 1;
      end
    end
  end
endmodule

/* verif/fshc_top_test.sv */
// self-checking bench for the seek and head-load sequencer
`timescale 1ns/100ps
module fshc_top_test;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic master_reset_n = 1'b1;
  logic test_n = 1'b1;
  logic density_select_n = 1'b0;
  logic track_zero_n, head_engaged, index_pulse, id_valid, id_crc_ok;
  logic [7:0] id_track;
  logic step_pulse, step_direction, head_load, side_select_out;
  logic interrupt_request, write_data, write_gate, ext_recovery_sel;
  logic tz_broken = 1'b0;
  logic [7:0] id_skew = 8'h00;
  logic [1:0] bad_crcs = 2'h0;
  logic stp_q = 1'b0;
  logic [31:0] q;
  int bad_count = 0;
  int checks = 0;
  int cyc = 0;
  int npuls = 0;
  int wid = 0;
  int gap = 0;
  int rise_at = 0;
  int nwd = 0;
  int t0;
  int n0;
  int ms[4] = '{3, 6, 10, 15};

  fshc_top #(.MS_CYCLES(10)) i_fshc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .master_reset_n(master_reset_n), .test_n(test_n),
    .density_select_n(density_select_n), .slow_clock_sel(1'b0), .track_zero_n(track_zero_n),
    .head_engaged(head_engaged), .index_pulse(index_pulse), .id_valid(id_valid),
    .id_track(id_track), .id_crc_ok(id_crc_ok), .step_pulse(step_pulse),
    .step_direction(step_direction), .head_load(head_load), .side_select_out(side_select_out),
    .interrupt_request(interrupt_request), .write_data(write_data), .write_gate(write_gate),
    .ext_recovery_sel(ext_recovery_sel));
  fshc_drive_model i_fshc_drive_model (.pclk(pclk), .presetn(presetn), .step_pulse(step_pulse),
    .step_direction(step_direction), .head_load(head_load), .start_cyl(8'h03),
    .tz_broken(tz_broken), .id_skew(id_skew), .bad_crcs(bad_crcs), .track_zero_n(track_zero_n),
    .head_engaged(head_engaged), .index_pulse(index_pulse), .id_valid(id_valid),
    .id_track(id_track), .id_crc_ok(id_crc_ok));

  // clock
  initial begin
    forever #5 pclk = ~pclk;
  end
  // step and write-data monitor, plus the hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    stp_q <= step_pulse;
    if (step_pulse) wid <= wid + 1;
    if (step_pulse && !stp_q) begin
      npuls <= npuls + 1;
      gap <= cyc - rise_at;
      rise_at <= cyc;
      wid <= 1;
    end
    if (write_data) nwd <= nwd + 1;
    if (cyc == 100000) begin
      bad_count++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d bad %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one apb transfer: setup, then access held until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // issue a command, wait for its interrupt, then read status into q
  task automatic run(input logic [7:0] c);
    n0 = npuls;
    t0 = cyc;
    apb(1'b1, fshc_pkg::REG_CMD, {24'h0, c});
    while (interrupt_request !== 1'b1 && cyc - t0 < 80000) @(posedge pclk);
    chk("irq", interrupt_request, 1'b1);
    apb(1'b0, fshc_pkg::REG_STATUS, 32'h0);
    chk("busy", q[fshc_pkg::ST_BUSY], 1'b0);
  endtask
  task automatic trk(input logic [7:0] e);
    apb(1'b0, fshc_pkg::REG_TRACK, 32'h0);
    chk("track", q, {24'h0, e});
  endtask

  task automatic t_power_restore();
    while (interrupt_request !== 1'b1 && cyc < 5000) @(posedge pclk);
    chk("irq", interrupt_request, 1'b1);
    chk("pulses", npuls, 3);
    chk("dir", step_direction, 1'b0);
    trk(8'h00);
    $display("test power restore done");
  endtask
  task automatic t_steps();
    apb(1'b1, fshc_pkg::REG_CMD, 32'h58);
    apb(1'b0, fshc_pkg::REG_STATUS, 32'h0);
    chk("busy", q[fshc_pkg::ST_BUSY], 1'b1);
    chk("hload", head_load, 1'b1);
    run(8'h58);
    chk("width", wid, 200);
    chk("dir", step_direction, 1'b1);
    trk(8'h01);
    run(8'h30);
    chk("dir", step_direction, 1'b1);
    trk(8'h02);
    run(8'h70);
    chk("dir", step_direction, 1'b0);
    trk(8'h01);
    run(8'h60);
    chk("pulses", npuls - n0, 1);
    trk(8'h01);
    run(8'h86);
    chk("delay", cyc - t0 > 150, 1'b1);
    chk("head", q[fshc_pkg::ST_HEAD], 1'b1);
    run(8'hd8);
    chk("pulses", npuls - n0, 0);
    run(8'h00);
    chk("hload", head_load, 1'b0);
    chk("side", side_select_out, 1'b1);
    $display("test steps done");
  endtask
  task automatic t_rates();
    for (int r = 0; r < 4; r++) begin
      density_select_n <= (r == 3);
      apb(1'b1, fshc_pkg::REG_DATA, (r % 2) ? 32'h0 : 32'h2);
      run(8'h10 | 8'(r));
      chk("pulses", npuls - n0, 2);
      chk("gap ok", 32'(gap - ms[r] * 10 - (r == 3 ? 400 : 200)) < 32'hb, 1'b1);
      trk((r % 2) ? 8'h00 : 8'h02);
    end
    chk("width", wid, 400);
    density_select_n <= 1'b0;
    $display("test rates done");
  endtask
  task automatic t_verify();
    bad_crcs <= 2'h1;
    apb(1'b1, fshc_pkg::REG_DATA, 32'h5);
    run(8'h1c);
    chk("crc err", q[fshc_pkg::ST_CRC], 1'b1);
    chk("seek err", q[fshc_pkg::ST_SEEK], 1'b0);
    chk("head", q[fshc_pkg::ST_HEAD], 1'b1);
    chk("settle", cyc - t0 > 150, 1'b1);
    id_skew <= 8'h40;
    run(8'h54);
    chk("seek err", q[fshc_pkg::ST_SEEK], 1'b1);
    chk("revs", (cyc - t0 >= 1600) && (cyc - t0 <= 3000), 1'b1);
    chk("hload", head_load, 1'b1);
    repeat (16 * 400 + 50) @(posedge pclk);
    chk("idle drop", head_load, 1'b0);
    id_skew <= 8'h00;
    $display("test verify done");
  endtask
  task automatic t_restore_fail();
    tz_broken <= 1'b1;
    run(8'h00);
    chk("pulses", npuls - n0, 255);
    chk("seek err", q[fshc_pkg::ST_SEEK], 1'b1);
    tz_broken <= 1'b0;
    $display("test restore limit done");
  endtask
  task automatic t_test_pin();
    test_n <= 1'b0;
    n0 = nwd;
    repeat (1000) @(posedge pclk);
    chk("wd pulses", nwd - n0 >= 4, 1'b1);
    chk("wgate", write_gate, 1'b0);
    master_reset_n <= 1'b0;
    repeat (4) @(posedge pclk);
    master_reset_n <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("ext rec", ext_recovery_sel, 1'b1);
    test_n <= 1'b1;
    master_reset_n <= 1'b0;
    repeat (4) @(posedge pclk);
    master_reset_n <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("ext rec", ext_recovery_sel, 1'b0);
    $display("test pin done");
  endtask

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_power_restore();
    apb(1'b0, fshc_pkg::REG_STATUS, 32'h0);
    t_steps();
    t_rates();
    t_verify();
    t_restore_fail();
    t_test_pin();
    end_of_test();
  end
endmodule
